// ---- dv/lcd_host_model.sv ----
// Host bus master model issuing register writes and reads
`timescale 1ns/100ps
module lcd_host_model (
    input wire logic clk_in,
    output logic [3:0] awaddr_out,
    output logic [31:0] wdata_out,
    output logic awvalid_out, wvalid_out, bready_out,
    output logic [3:0] araddr_out,
    output logic arvalid_out, rready_out, hang_out,
    input wire logic awready_in, wready_in, bvalid_in,
    input wire logic arready_in, rvalid_in
);
    initial begin
        {awaddr_out, wdata_out, araddr_out} = '0;
        {awvalid_out, wvalid_out, bready_out} = 3'h0;
        {arvalid_out, rready_out, hang_out} = 3'h0;
    end
    // Each item drops only at the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        awaddr_out <= a;
        wdata_out <= d;
        {awvalid_out, wvalid_out, bready_out} <= 3'h7;
        do begin
            @(posedge clk_in);
            n++;
            if (awready_in) awvalid_out <= 1'b0;
            if (wready_in) wvalid_out <= 1'b0;
        end while (!bvalid_in && n < 64);
        bready_out <= 1'b0;
        if (n == 64) hang_out <= 1'b1;
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge clk_in);
        araddr_out <= a;
        {arvalid_out, rready_out} <= 2'h3;
        do begin
            @(posedge clk_in);
            n++;
            if (arready_in) arvalid_out <= 1'b0;
        end while (!rvalid_in && n < 64);
        rready_out <= 1'b0;
        if (n == 64) hang_out <= 1'b1;
    endtask
endmodule

// ---- dv/lcd_scroll_lp_monitor.sv ----
// Concurrent checks on the scroll and low-power controller ports
`timescale 1ns/100ps
module lcd_scroll_lp_monitor #(parameter int OSC_DIV = 4) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic LOW_POWER_OUT,
    input wire logic OP_TICK_OUT,
    input wire logic FRAME_TICK_OUT,
    input wire logic [5:0] SCROLL_AMOUNT_OUT
);
    logic [7:0] gap_q;
    logic lp_any_q;
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Gap is zero until the first tick so reset phase is never judged
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            gap_q <= 8'h00;
            lp_any_q <= 1'b0;
        end else if (OP_TICK_OUT) begin
            gap_q <= 8'h01;
            lp_any_q <= LOW_POWER_OUT;
        end else begin
            gap_q <= (gap_q == 8'h00) ? 8'h00 : gap_q + 8'h01;
            lp_any_q <= lp_any_q | LOW_POWER_OUT;
        end
    end
    sequence s_ar_take;
        S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    endsequence
    sequence s_b_wait;
        S_AXI_BVALID_OUT && !S_AXI_BREADY_IN;
    endsequence
    AST_R_ANSWER: assert property (s_ar_take |=> S_AXI_RVALID_OUT)
        else $error("read answer not one cycle after take");
    AST_B_STAND: assert property (s_b_wait |=> S_AXI_BVALID_OUT)
        else $error("write response dropped early");
    AST_R_STAND: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
        |=> S_AXI_RVALID_OUT) else $error("read data dropped early");
    AST_AW_BLOCK: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT)
        else $error("write address taken during response");
    AST_AR_BLOCK: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
        else $error("read address taken during answer");
    AST_LP_NOSHIFT: assert property (
        LOW_POWER_OUT && $past(LOW_POWER_OUT) |-> SCROLL_AMOUNT_OUT == 6'h00)
        else $error("shift applied in low power");
    AST_OP_GAP: assert property (
        OP_TICK_OUT && gap_q != 8'h00 && !lp_any_q && !LOW_POWER_OUT
        |-> gap_q == OSC_DIV) else $error("normal tick spacing wrong");
    AST_OP_PULSE: assert property (OP_TICK_OUT |=> !OP_TICK_OUT)
        else $error("operating tick longer than one cycle");
    // In low power frames follow the base divider, not the slowed clock
    AST_FRAME_SYNC: assert property (
        !$past(LOW_POWER_OUT) |-> FRAME_TICK_OUT == OP_TICK_OUT)
        else $error("normal frame tick not on operating tick");
endmodule
bind lcd_scroll_lp_ctrl lcd_scroll_lp_monitor #(.OSC_DIV(OSC_DIV)) mon_u (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN),
    .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
    .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
    .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .LOW_POWER_OUT(LOW_POWER_OUT), .OP_TICK_OUT(OP_TICK_OUT),
    .FRAME_TICK_OUT(FRAME_TICK_OUT), .SCROLL_AMOUNT_OUT(SCROLL_AMOUNT_OUT)
);

// ---- dv/tb_lcd_scroll_lp_ctrl.sv ----
// Self-checking bench for the scroll and low-power controller
`timescale 1ns/100ps
module tb_lcd_scroll_lp_ctrl;
    localparam int DIV = 4;
    localparam logic [3:0] CT = lcd_scroll_lp_pkg::CTRL_OFS;
    localparam logic [3:0] SC = lcd_scroll_lp_pkg::SCROLL_OFS;
    localparam logic [3:0] LS = lcd_scroll_lp_pkg::LINESEL_OFS;
    localparam logic [3:0] ST = lcd_scroll_lp_pkg::STATUS_OFS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic exp_in = 1'b0;
    logic [3:0] aw_a, ar_a, s_ln, ln;
    logic [31:0] w_d, r_d;
    logic [1:0] b_resp, r_resp;
    logic [5:0] s_amt, amt;
    logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, hang;
    logic lp, op, fr, sh, six;
    logic [33:0] bq[$];
    logic [33:0] rq[$];
    int n_mismatch = 0;
    int checks = 0;
    int fcnt = 0;
    int c, f0;
    always #4 clk = ~clk;
    lcd_scroll_lp_ctrl #(.OSC_DIV(DIV)) dut_u (.CORE_CLK_IN(clk),
        .RST_N_IN(rst_n), .EXPANSION_DRIVER_USED_IN(exp_in),
        .S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v),
        .S_AXI_AWREADY_OUT(aw_r), .S_AXI_WDATA_IN(w_d),
        .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(w_r),
        .S_AXI_BRESP_OUT(b_resp), .S_AXI_BVALID_OUT(b_v),
        .S_AXI_BREADY_IN(b_r), .S_AXI_ARADDR_IN(ar_a),
        .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(ar_r),
        .S_AXI_RDATA_OUT(r_d), .S_AXI_RRESP_OUT(r_resp),
        .S_AXI_RVALID_OUT(r_v), .S_AXI_RREADY_IN(r_r), .LOW_POWER_OUT(lp),
        .OP_TICK_OUT(op), .FRAME_TICK_OUT(fr), .SHIFT_ACTIVE_OUT(sh),
        .SCROLL_AMOUNT_OUT(s_amt), .SCROLL_LINES_OUT(s_ln),
        .SIX_DOT_OUT(six));
    lcd_host_model host_u (.clk_in(clk), .awaddr_out(aw_a), .wdata_out(w_d),
        .awvalid_out(aw_v), .wvalid_out(w_v), .bready_out(b_r),
        .araddr_out(ar_a), .arvalid_out(ar_v), .rready_out(r_r),
        .hang_out(hang), .awready_in(aw_r), .wready_in(w_r),
        .bvalid_in(b_v), .arready_in(ar_r), .rvalid_in(r_v));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        if (fr === 1'b1) fcnt <= fcnt + 1;
        if (b_v === 1'b1 && b_r === 1'b1) chk({32'h0, b_resp}, bq.pop_front());
        if (r_v === 1'b1 && r_r === 1'b1) chk({r_resp, r_d}, rq.pop_front());
    end
    always @(posedge hang) begin
        n_mismatch++;
        results();
    end
    task automatic w(input logic [3:0] a, input logic [31:0] d);
        bq.push_back({32'h0, lcd_scroll_lp_pkg::RESP_OKAY});
        host_u.wr(a, d);
    endtask
    task automatic r(input logic [3:0] a, input logic [31:0] d);
        rq.push_back({lcd_scroll_lp_pkg::RESP_OKAY, d});
        host_u.rd(a);
    endtask
    task automatic tick();
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (op !== 1'b1 && c < 100);
        if (c == 100) begin
            n_mismatch++;
            results();
        end
    endtask
    // First spacing after a mode change may be partial, so skip two
    // Frames run on base ticks: window holds 12*g/DIV of them
    task automatic rate(input int g, input int nf);
        repeat (3) tick();
        chk(c, g);
        f0 = fcnt;
        repeat (12) tick();
        chk(fcnt - f0, nf);
    endtask
    initial begin
        void'($urandom(32'h4454_ca32));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        r(CT, 32'h0);
        r(SC, 32'h0);
        r(LS, 32'h0);
        r(ST, 32'h0);
        rq.push_back({lcd_scroll_lp_pkg::RESP_SLVERR, 32'h0});
        host_u.rd(4'h6);
        bq.push_back({32'h0, lcd_scroll_lp_pkg::RESP_SLVERR});
        host_u.wr(ST, 32'h1);
        r(ST, 32'h0);
        $display("test reset done");
        w(SC, 32'h15);
        r(SC, 32'h0);
        amt = 6'($urandom_range(63, 1));
        ln = 4'($urandom_range(15, 1));
        w(CT, 32'h3);
        w(SC, {26'h0, amt});
        w(LS, {28'h0, ln});
        r(SC, {26'h0, amt});
        repeat (3) @(posedge clk);
        chk({s_amt, s_ln, sh, six}, {amt, ln, 2'b11});
        $display("test scroll done");
        exp_in <= 1'b1;
        repeat (4) @(posedge clk);
        w(CT, 32'h5);
        r(ST, 32'h6);
        exp_in <= 1'b0;
        w(CT, 32'h0);
        w(CT, 32'h4);
        repeat (4) @(posedge clk);
        chk(lp, 1'b0);
        w(CT, 32'h1);
        w(CT, 32'h21);
        w(SC, 32'h0);
        w(CT, 32'h5);
        r(ST, 32'h1);
        chk({lp, sh, s_amt, s_ln}, 12'h800);
        w(SC, {26'h0, amt});
        repeat (2) @(posedge clk);
        chk({sh, s_amt, s_ln}, 11'h0);
        r(SC, {26'h0, amt});
        w(SC, 32'h0);
        rate(DIV * 4, 40);
        w(CT, 32'hD);
        rate(DIV * 2, 20);
        w(CT, 32'h15);
        rate(DIV * 2, 20);
        $display("test low power done");
        w(CT, 32'h9);
        r(ST, 32'hA);
        w(CT, 32'h29);
        r(ST, 32'h0);
        rate(DIV, 12);
        $display("test exit done");
        results();
    end
endmodule

// ---- rtl/lcd_scroll_lp_ctrl.sv ----
// Scroll and low-power control with an AXI4-Lite register slave
//
// Summary of operation
// - Scroll amount register accepts writes only while extended bank is 1.
// - Scroll applies only to lines enabled in the line-select register.
// - Char width select 1 gives 6-dot font for smooth scrolling.
// - Low power entered on bit write when bank is 1, no expansion.
// - Low power divides internal clock by 2 (2/4-line) or 4 (1-line).
// - Low power reduces frame rate to five sixths.
// - No display shift is applied while in low power.
// - Leaving low power leaves the display in a shifted state.
`timescale 1ns/100ps
module lcd_scroll_lp_ctrl #(
    parameter int OSC_DIV = lcd_scroll_lp_pkg::OSC_DIV
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic EXPANSION_DRIVER_USED_IN,
    input wire logic [3:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [3:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    output logic LOW_POWER_OUT,
    output logic OP_TICK_OUT,
    output logic FRAME_TICK_OUT,
    output logic SHIFT_ACTIVE_OUT,
    output logic [5:0] SCROLL_AMOUNT_OUT,
    output logic [3:0] SCROLL_LINES_OUT,
    output logic SIX_DOT_OUT
);
    localparam int SW = lcd_scroll_lp_pkg::SCROLL_W;
    localparam int LN = lcd_scroll_lp_pkg::LINES_MAX;

    // Expansion input is asynchronous to the core clock
    logic ext_meta_q;
    logic ext_sync_q;
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end else begin
            ext_meta_q <= EXPANSION_DRIVER_USED_IN;
            ext_sync_q <= ext_meta_q;
        end
    end

    // Write channel: address and data latched independently
    logic aw_full_q;
    logic w_full_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic awready_q;
    logic wready_q;
    wire aw_take = S_AXI_AWVALID_IN && awready_q;
    wire w_take = S_AXI_WVALID_IN && wready_q;
    wire wr_go = aw_full_q && w_full_q && !bvalid_q;
    // Readies come from next state, so the ports are plain flops
    wire aw_full_d = !wr_go && (aw_full_q || aw_take);
    wire w_full_d = !wr_go && (w_full_q || w_take);
    wire bvalid_d = wr_go || (bvalid_q && !S_AXI_BREADY_IN);
    wire wr_ctrl = wr_go && aw_addr_q == lcd_scroll_lp_pkg::CTRL_OFS;
    wire wr_scroll = wr_go && aw_addr_q == lcd_scroll_lp_pkg::SCROLL_OFS;
    wire wr_lines = wr_go && aw_addr_q == lcd_scroll_lp_pkg::LINESEL_OFS;
    wire wr_known = wr_ctrl || wr_scroll || wr_lines;

    // Configuration state
    logic bank_q;
    logic six_dot_q;
    logic [1:0] line_mode_q;
    logic lp_q;
    logic shifted_q;
    logic [SW-1:0] amount_q;
    logic [LN-1:0] lines_q;
    wire ctrl_lane = wr_ctrl && w_strb_q[0];
    wire new_bank = w_data_q[lcd_scroll_lp_pkg::CTRL_BANK_BIT];
    wire new_lp = w_data_q[lcd_scroll_lp_pkg::CTRL_LP_BIT];
    wire home_cmd = ctrl_lane && w_data_q[lcd_scroll_lp_pkg::CTRL_HOME_BIT];
    // LP only changes with the extended bank open; entry also needs no EXPANSION_DRIVER_USED
    wire lp_set = ctrl_lane && bank_q && new_lp && !ext_sync_q;
    wire lp_clr = ctrl_lane && bank_q && !new_lp;
    wire scroll_ok = wr_scroll && w_strb_q[0] && bank_q;

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= lcd_scroll_lp_pkg::RESP_OKAY;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end else begin
            awready_q <= !aw_full_d && !bvalid_d;
            wready_q <= !w_full_d && !bvalid_d;
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_IN;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= S_AXI_WDATA_IN;
                w_strb_q <= S_AXI_WSTRB_IN;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? lcd_scroll_lp_pkg::RESP_OKAY
                                    : lcd_scroll_lp_pkg::RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY_IN) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bank_q <= lcd_scroll_lp_pkg::CTRL_RST[0];
            six_dot_q <= lcd_scroll_lp_pkg::CTRL_RST[1];
            line_mode_q <= lcd_scroll_lp_pkg::CTRL_RST[4:3];
            lp_q <= lcd_scroll_lp_pkg::CTRL_RST[2];
            shifted_q <= 1'b0;
            amount_q <= lcd_scroll_lp_pkg::SCROLL_RST;
            lines_q <= lcd_scroll_lp_pkg::LINESEL_RST;
        end else begin
            if (ctrl_lane) begin
                bank_q <= new_bank;
                six_dot_q <= w_data_q[lcd_scroll_lp_pkg::CTRL_FW_BIT];
                line_mode_q <= w_data_q[lcd_scroll_lp_pkg::CTRL_LINES_LSB+:2];
            end
            if (lp_set) begin
                lp_q <= 1'b1;
            end else if (lp_clr) begin
                lp_q <= 1'b0;
            end
            // Leaving low power leaves a stale shift until a home command
            if (lp_clr && lp_q) begin
                shifted_q <= 1'b1;
            end else if (home_cmd) begin
                shifted_q <= 1'b0;
            end
            if (scroll_ok) begin
                amount_q <= w_data_q[SW-1:0];
            end
            if (wr_lines && w_strb_q[0]) begin
                lines_q <= w_data_q[LN-1:0];
            end
        end
    end

    // Read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic arready_q;
    wire ar_take = S_AXI_ARVALID_IN && arready_q;
    wire rvalid_d = ar_take || (rvalid_q && !S_AXI_RREADY_IN);
    wire [31:0] ctrl_view = {26'h000_0000, 1'b0, line_mode_q, lp_q,
                             six_dot_q, bank_q};
    wire [31:0] status_view = {28'h000_0000, shifted_q, ext_sync_q,
                               SHIFT_ACTIVE_OUT, lp_q};
    wire rd_ctrl = S_AXI_ARADDR_IN == lcd_scroll_lp_pkg::CTRL_OFS;
    wire rd_scroll = S_AXI_ARADDR_IN == lcd_scroll_lp_pkg::SCROLL_OFS;
    wire rd_lines = S_AXI_ARADDR_IN == lcd_scroll_lp_pkg::LINESEL_OFS;
    wire rd_status = S_AXI_ARADDR_IN == lcd_scroll_lp_pkg::STATUS_OFS;
    wire rd_known = rd_ctrl || rd_scroll || rd_lines || rd_status;
    wire [31:0] rd_mux = rd_ctrl ? ctrl_view :
                         rd_scroll ? {26'h000_0000, amount_q} :
                         rd_lines ? {28'h000_0000, lines_q} :
                         rd_status ? status_view : 32'h0000_0000;

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= lcd_scroll_lp_pkg::RESP_OKAY;
            arready_q <= 1'b1;
        end else begin
            arready_q <= !rvalid_d;
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_known ? lcd_scroll_lp_pkg::RESP_OKAY
                                    : lcd_scroll_lp_pkg::RESP_SLVERR;
            end else if (rvalid_q && S_AXI_RREADY_IN) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Internal operating clock as enables: base divider, then LP divider
    logic [$clog2(OSC_DIV)-1:0] osc_cnt_q;
    logic [1:0] lp_cnt_q;
    logic [2:0] frame_cnt_q;
    logic op_tick_q;
    logic frame_tick_q;
    wire osc_tick = osc_cnt_q == ($clog2(OSC_DIV))'(OSC_DIV - 1);
    // 1-line mode divides by 4, 2/4-line by 2
    wire [1:0] lp_last = line_mode_q == lcd_scroll_lp_pkg::LINES_1
                         ? 2'd3 : 2'd1;
    wire op_tick = osc_tick && (!lp_q || lp_cnt_q == lp_last);
    // Frame counter: in low power, one tick in six is swallowed
    wire frame_last = frame_cnt_q == 3'(lcd_scroll_lp_pkg::FRAME_TICKS - 1);
    wire frame_keep = !lp_q ||
        frame_cnt_q < 3'(lcd_scroll_lp_pkg::LP_FRAME_KEEP);

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            osc_cnt_q <= '0;
            lp_cnt_q <= 2'd0;
            frame_cnt_q <= 3'd0;
            op_tick_q <= 1'b0;
            frame_tick_q <= 1'b0;
        end else begin
            osc_cnt_q <= osc_tick ? '0 : osc_cnt_q + 1'b1;
            if (osc_tick) begin
                lp_cnt_q <= (!lp_q || lp_cnt_q == lp_last) ? 2'd0
                                                            : lp_cnt_q + 2'd1;
                frame_cnt_q <= frame_last ? 3'd0 : frame_cnt_q + 3'd1;
            end
            op_tick_q <= op_tick;
            frame_tick_q <= osc_tick && frame_keep;
        end
    end

    // Display outputs: shift suppressed during low power
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SHIFT_ACTIVE_OUT <= 1'b0;
            SCROLL_AMOUNT_OUT <= 6'h00;
            SCROLL_LINES_OUT <= 4'h0;
        end else begin
            SHIFT_ACTIVE_OUT <= !lp_q && (|amount_q || shifted_q);
            SCROLL_AMOUNT_OUT <= lp_q ? 6'h00 : amount_q;
            SCROLL_LINES_OUT <= lp_q ? 4'h0 : lines_q;
        end
    end

    assign S_AXI_AWREADY_OUT = awready_q;
    assign S_AXI_WREADY_OUT = wready_q;
    assign S_AXI_BVALID_OUT = bvalid_q;
    assign S_AXI_BRESP_OUT = bresp_q;
    assign S_AXI_ARREADY_OUT = arready_q;
    assign S_AXI_RVALID_OUT = rvalid_q;
    assign S_AXI_RDATA_OUT = rdata_q;
    assign S_AXI_RRESP_OUT = rresp_q;
    assign LOW_POWER_OUT = lp_q;
    assign OP_TICK_OUT = op_tick_q;
    assign FRAME_TICK_OUT = frame_tick_q;
    assign SIX_DOT_OUT = six_dot_q;
endmodule

// ---- rtl/lcd_scroll_lp_pkg.sv ----
// Package: register map, field layout, reset values and timing constants
package lcd_scroll_lp_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] SCROLL_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] LINESEL_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'hC;
    // Control register fields
    localparam int CTRL_BANK_BIT = 0;
    localparam int CTRL_FW_BIT = 1;
    localparam int CTRL_LP_BIT = 2;
    localparam int CTRL_LINES_LSB = 3;
    localparam int CTRL_HOME_BIT = 5;
    localparam int SCROLL_W = 6;
    localparam int LINES_MAX = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [SCROLL_W-1:0] SCROLL_RST = 6'h00;
    localparam logic [LINES_MAX-1:0] LINESEL_RST = 4'h0;
    // Internal operating clock: base period in core cycles
    localparam int CLK_HZ = 125_000_000;
    localparam int OSC_HZ = 250_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    // Frame: 6 internal ticks normally; 5 of 6 pass in low power
    localparam int FRAME_TICKS = 6;
    localparam int LP_FRAME_KEEP = 5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        LINES_1 = 2'b00,
        LINES_2 = 2'b01,
        LINES_4 = 2'b10
    } line_mode_e;
    typedef struct packed {
        logic [SCROLL_W-1:0] amount;
        logic [LINES_MAX-1:0] lines;
        logic six_dot;
    } scroll_s;
endpackage
